//--- common/fmc_params.svh
`ifndef FMC_PARAMS_SVH
`define FMC_PARAMS_SVH
`define FMC_CFG_W        16
`define FMC_CFG_RESET    16'h0000
`define FMC_SIZE_LSB     0
`define FMC_SIZE_MSB     2
`define FMC_SHIFT_BIT    3
`define FMC_OVL_LSB      6
`define FMC_OVL_MSB      8
`define FMC_DEVM_LSB     9
`define FMC_DEVM_MSB     10
`define FMC_LOAD_START_INPUT_SIMPLE  12
`define FMC_FIFO_DEPTH   16
`define FMC_FIFO_AW      4
`define FMC_FIRST_SHIFT  2
`define FMC_LATER_SHIFT3 3
`define FMC_LATER_SHIFT2 2
`define FMC_MAXLS_SH3    4'hF
`define FMC_MAXLS_SH2    4'hE
`define FMC_OVF_TAG      4'hF
`endif

//--- common/fmc_pkg.sv
package fmc_pkg;
  typedef enum logic [2:0] {
    FMC_SZ_16X16C, FMC_SZ_4X64C, FMC_SZ_256C, FMC_SZ_1024C,
    FMC_SZ_8X64R, FMC_SZ_2X256R, FMC_SZ_2X1024R, FMC_SZ_UNUSED
  } fmc_size_t;
  typedef enum logic [1:0] {
    FMC_DM_SINGLE, FMC_DM_CONC, FMC_DM_LTD, FMC_DM_SPECIAL
  } fmc_devmode_t;
  typedef struct packed {
    logic [15:11] upper;
    fmc_devmode_t devmode;
    logic [2:0]   overlap;
    logic [1:0]   window;
    logic         shift2;
    fmc_size_t    size;
  } fmc_cfg_t;
  typedef struct packed {
    logic [15:0] re;
    logic [15:0] im;
  } fmc_sample_t;
  typedef struct packed {
    logic [1:0] pass_shift;
    logic [3:0] max_left;
    logic       ovf_tag_en;
    logic       concurrent;
    logic       real_only;
  } fmc_plan_t;
endpackage

//--- hw/fmc_fifo.sv
`timescale 1ns/10ps
module fmc_fifo
#(
  parameter int W  = 32,
  parameter int D  = 16,
  parameter int AW = 4
)
(
  input  wire logic         mclk,    // clock
  input  wire logic         rst_n,   // async reset
  input  wire logic         in_valid, // write request
  output logic              in_ready, // not full
  input  wire logic [W-1:0] in_data,  // write word
  output logic              out_valid, // not empty
  input  wire logic         out_ready, // read accept
  output logic [W-1:0]      out_data   // head word
);
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
  logic         wr, rd;

  assign in_ready  = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
  assign out_valid = (wp_q != rp_q);
  assign out_data  = mem_q[rp_q[AW-1:0]];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;

  always_comb
  begin
    wp_d = wr ? wp_q + 1'b1 : wp_q;
    rp_d = rd ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (wr)
      mem_q[wp_q[AW-1:0]] <= in_data;
  end
endmodule

//--- hw/fmc_plan.sv
`timescale 1ns/10ps
`include "fmc_params.svh"
module fmc_plan
  import fmc_pkg::*;
(
  input  fmc_cfg_t  cfg,   // captured mode word
  output fmc_plan_t plan   // derived data-path plan
);
  logic big;
  assign big = (cfg.size == FMC_SZ_1024C) || (cfg.size == FMC_SZ_2X1024R);
  always_comb
  begin
    plan.pass_shift = cfg.shift2 ? 2'(`FMC_LATER_SHIFT2) : 2'(`FMC_LATER_SHIFT3);
    plan.max_left   = cfg.shift2 ? `FMC_MAXLS_SH2 : `FMC_MAXLS_SH3;
    plan.ovf_tag_en = cfg.shift2;
    plan.concurrent = !big && (cfg.devmode == FMC_DM_SINGLE || cfg.devmode == FMC_DM_CONC);
    plan.real_only  = cfg.size[2] && (cfg.devmode == FMC_DM_CONC || cfg.devmode == FMC_DM_LTD);
  end
endmodule

//--- hw/fmc_top.sv
`timescale 1ns/10ps
`include "fmc_params.svh"
module fmc_top
  import fmc_pkg::*;
(
  input  wire logic        mclk,                // system clock
  input  wire logic        rst_n,               // async reset
  input  wire logic        mode_define_strobe,  // high: capture mode word
  input  wire logic [15:0] auxiliary_input_bus, // mode word / imaginary data
  input  wire logic [15:0] real_in,             // real data
  input  wire logic        input_strobe,        // sample strobe
  input  wire logic        load_start_input,    // load-start
  input  wire logic        xform_done,          // transform engine finished
  input  wire logic        dump_done,           // dump finished
  input  wire logic        smp_ready,           // consumer accepts sample
  output logic             smp_valid,           // sample available
  output fmc_sample_t      smp_data,            // buffered sample
  output logic             load_progress_flag,  // load progress
  output logic             xform_go,            // start transform
  output logic             loading,             // load in progress
  output logic [1:0]       first_shift,         // first pass shift
  output fmc_plan_t        plan                 // derived shift and mode plan
);
  typedef enum logic [1:0] { FMC_IDLE, FMC_LOAD, FMC_XFRM, FMC_DUMP } fmc_st_t;

  fmc_cfg_t    cfg_q, cfg_d;
  fmc_st_t     st_q, st_d;
  logic [10:0] cnt_q, cnt_d;
  logic [2:0]  blk_q, blk_d;
  logic        flag_q, flag_d;
  logic        start_prev_q, start_edge, start_go;
  logic [10:0] blk_len, tot_len, drop_pt;
  logic [2:0]  nblk;
  logic        grouped, fifo_ready;
  fmc_sample_t smp_in;

  always_comb
  begin
    cfg_d = cfg_q;
    if (mode_define_strobe)
      cfg_d = fmc_cfg_t'(auxiliary_input_bus);
  end

  fmc_plan u_plan
  (
    .cfg  (cfg_q),
    .plan (plan)
  );

  assign first_shift = 2'(`FMC_FIRST_SHIFT);

  always_comb
  begin
    unique case (cfg_q.size)
      FMC_SZ_16X16C:  begin blk_len = 11'd16;   nblk = 3'd1; end
      FMC_SZ_4X64C:   begin blk_len = 11'd64;   nblk = 3'd4; end
      FMC_SZ_256C:    begin blk_len = 11'd256;  nblk = 3'd1; end
      FMC_SZ_1024C:   begin blk_len = 11'd1024; nblk = 3'd1; end
      FMC_SZ_8X64R:   begin blk_len = 11'd64;   nblk = 3'd7; end
      FMC_SZ_2X256R:  begin blk_len = 11'd256;  nblk = 3'd2; end
      FMC_SZ_2X1024R: begin blk_len = 11'd1024; nblk = 3'd1; end
      default:        begin blk_len = 11'd16;   nblk = 3'd1; end
    endcase
  end
  assign grouped = (nblk != 3'd1);

  always_comb
  begin
    unique case (cfg_q.overlap)
      3'b001, 3'b010, 3'b110: drop_pt = blk_len >> 1;
      3'b011, 3'b100, 3'b111: drop_pt = blk_len >> 2;
      default:                drop_pt = blk_len;
    endcase
  end

  always_comb
  begin
    tot_len = blk_len;
    if (cfg_q.devmode == FMC_DM_SPECIAL && drop_pt != blk_len)
      tot_len = grouped ? (blk_len << 1) : (blk_len + (blk_len >> 1));
  end

  assign start_edge = load_start_input && !start_prev_q;
  assign start_go   = (cfg_q.devmode == FMC_DM_SINGLE && cfg_q.upper[`FMC_LOAD_START_INPUT_SIMPLE])
                      ? load_start_input : start_edge;

  assign smp_in.re = real_in;
  assign smp_in.im = plan.real_only ? 16'h0000 : auxiliary_input_bus;

  always_comb
  begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    blk_d    = blk_q;
    flag_d   = flag_q;
    xform_go = 1'b0;
    unique case (st_q)
      FMC_IDLE:
      begin
        flag_d = 1'b1;
        if (start_go)
        begin
          st_d  = FMC_LOAD;
          cnt_d = '0;
          blk_d = '0;
        end
      end
      FMC_LOAD:
      begin
        if (input_strobe && fifo_ready && !mode_define_strobe)
        begin
          cnt_d = cnt_q + 11'd1;
          // special: single drop at the end of the last block's normal length
          if (cfg_q.devmode == FMC_DM_SPECIAL)
          begin
            if (cnt_q + 11'd1 == blk_len && blk_q == nblk - 3'd1)
              flag_d = 1'b0;
          end
          else if (cnt_q + 11'd1 == drop_pt)
          begin
            // grouped concurrent: drop in first and last block
            if (cfg_q.devmode == FMC_DM_CONC && grouped)
              flag_d = (blk_q == 3'd0 || blk_q == nblk - 3'd1) ? 1'b0 : flag_q;
            // otherwise: drop in first block only
            else
              flag_d = (blk_q == 3'd0) ? 1'b0 : flag_q;
          end
          else if (cfg_q.devmode == FMC_DM_CONC && grouped && blk_q == 3'd1
                   && cnt_q == 11'd0)
            flag_d = 1'b1;
          if (cnt_q + 11'd1 == ((blk_q == nblk - 3'd1) ? tot_len : blk_len))
          begin
            cnt_d = '0;
            if (blk_q == nblk - 3'd1)
            begin
              xform_go = 1'b1;
              // concurrent: ready for next load at once
              st_d = plan.concurrent ? FMC_IDLE : FMC_XFRM;
            end
            else
              blk_d = blk_q + 3'd1;
          end
        end
      end
      FMC_XFRM:
        if (xform_done)
          st_d = FMC_DUMP;
      FMC_DUMP:
        if (dump_done)
          st_d = FMC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q        <= fmc_cfg_t'(`FMC_CFG_RESET);
      st_q         <= FMC_IDLE;
      cnt_q        <= '0;
      blk_q        <= '0;
      flag_q       <= 1'b1;
      start_prev_q <= 1'b0;
    end
    else
    begin
      cfg_q        <= cfg_d;
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      blk_q        <= blk_d;
      flag_q       <= flag_d;
      start_prev_q <= load_start_input;
    end
  end

  assign load_progress_flag = flag_q;
  assign loading            = (st_q == FMC_LOAD);

  fmc_fifo #(.W($bits(fmc_sample_t)), .D(`FMC_FIFO_DEPTH), .AW(`FMC_FIFO_AW)) u_fifo
  (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (loading && input_strobe && !mode_define_strobe),
    .in_ready  (fifo_ready),
    .in_data   (smp_in),
    .out_valid (smp_valid),
    .out_ready (smp_ready),
    .out_data  (smp_data)
  );

  a_cfg_capture: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_define_strobe |=> cfg_q == $past(auxiliary_input_bus))
    else $error("mode word not captured");
  a_cfg_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !mode_define_strobe |=> $stable(cfg_q))
    else $error("mode word changed without define");
  a_start_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
    (loading && start_edge && !xform_go) |=> loading)
    else $error("load restarted");
  a_real_only: assert property (@(posedge mclk) disable iff (!rst_n)
    (smp_valid && plan.real_only) |-> smp_data.im == 16'h0000)
    else $error("aux data used in real-only mode");
  a_big_seq: assert property (@(posedge mclk) disable iff (!rst_n)
    (xform_go && (cfg_q.size == FMC_SZ_1024C || cfg_q.size == FMC_SZ_2X1024R))
    |=> st_q == FMC_XFRM)
    else $error("1024 not sequential");
  a_conc_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (xform_go && cfg_q.devmode == FMC_DM_CONC && cfg_q.size == FMC_SZ_256C)
    |=> st_q == FMC_IDLE)
    else $error("concurrent mode stalled");
  a_single_small: assert property (@(posedge mclk) disable iff (!rst_n)
    (xform_go && cfg_q.devmode == FMC_DM_SINGLE && cfg_q.size == FMC_SZ_256C)
    |=> st_q == FMC_IDLE)
    else $error("single-device load not overlapped");
  a_special_seq: assert property (@(posedge mclk) disable iff (!rst_n)
    (xform_go && cfg_q.devmode == FMC_DM_SPECIAL) |=> st_q == FMC_XFRM)
    else $error("special mode overlapped");
  a_ltd_seq: assert property (@(posedge mclk) disable iff (!rst_n)
    (xform_go && cfg_q.devmode == FMC_DM_LTD) |=> st_q == FMC_XFRM)
    else $error("load-transform-dump overlapped");
  a_shift_set: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_q.shift2 |-> (plan.pass_shift == 2'd2 && plan.max_left == 4'hE))
    else $error("shift-two plan wrong");
  a_shift_clr: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_q.shift2 |-> (plan.pass_shift == 2'd3 && plan.max_left == 4'hF))
    else $error("shift-three plan wrong");
  a_first_pass: assert property (@(posedge mclk) disable iff (!rst_n)
    first_shift == 2'd2)
    else $error("first pass shift wrong");
  a_load_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    ($rose(loading) && cfg_q.devmode != FMC_DM_SINGLE) |-> $past(start_edge))
    else $error("load without start edge");
  a_flag_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == FMC_IDLE) |=> load_progress_flag)
    else $error("flag low while idle");
  a_group_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    ($rose(load_progress_flag) && $past(loading))
    |-> (cfg_q.devmode == FMC_DM_CONC && grouped && blk_q == 3'd1))
    else $error("flag rose outside grouped load");
  a_ltd_first: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_q.devmode == FMC_DM_LTD && $fell(load_progress_flag)) |-> $past(blk_q) == 3'd0)
    else $error("second flag drop in sequential mode");
  sequence s_special_fall;
    cfg_q.devmode == FMC_DM_SPECIAL && $fell(load_progress_flag);
  endsequence
  a_special_drop: assert property (@(posedge mclk) disable iff (!rst_n)
    s_special_fall |-> ($past(cnt_q) == blk_len - 11'd1 && $past(blk_q) == nblk - 3'd1))
    else $error("special flag drop misplaced");
endmodule

//--- verif/fmc_sink_model.sv
`timescale 1ns/10ps
module fmc_sink_model
  import fmc_pkg::*;
(
  input  wire logic   mclk,       // clock
  input  wire logic   rst_n,      // reset
  input  wire logic   clr,        // restart order check
  input  wire logic   stall,      // hold consumer off
  input  wire logic   ro,         // expect zero imaginary
  input  wire logic   smp_valid,  // sample offered
  input  fmc_sample_t smp_data,   // sample
  output logic        smp_ready,  // accept
  input  wire logic   xform_go,   // transform start
  output logic        xform_done, // transform end pulse
  output logic        dump_done,  // dump end pulse
  output int          got,        // samples taken
  output int          bad         // order or pairing faults
);
  int          t;
  logic [15:0] last;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      smp_ready  <= 1'b0;
      xform_done <= 1'b0;
      dump_done  <= 1'b0;
      t          <= 0;
      got        <= 0;
      bad        <= 0;
      last       <= 16'h0000;
    end
    else
    begin
      smp_ready  <= !stall;
      xform_done <= (t == 8);
      dump_done  <= (t == 16);
      t          <= xform_go ? 1 : ((t > 0 && t < 16) ? t + 1 : 0);
      if (clr)
      begin
        got  <= 0;
        last <= 16'h0000;
      end
      else if (smp_valid && smp_ready)
      begin
        got  <= got + 1;
        last <= smp_data.re;
        if (smp_data.re <= last || smp_data.im !== (ro ? 16'h0000 : smp_data.re + 16'h0001))
          bad <= bad + 1;
      end
    end
  end
endmodule

//--- verif/test_fmc_top.sv
`timescale 1ns/10ps
module test_fmc_top;
  import fmc_pkg::*;
  logic        mclk, rst_n, mode_define_strobe, input_strobe, load_start_input;
  logic [15:0] auxiliary_input_bus, real_in;
  logic        xform_done, dump_done, smp_ready, smp_valid, load_progress_flag;
  logic        xform_go, loading, stall, clr, ro;
  logic [1:0]  first_shift;
  fmc_sample_t smp_data;
  fmc_plan_t   plan;
  int          got, bad, err_count, total_checks;
  // no 1024 size in concurrent mode
  logic [15:0] words [7] = '{16'h0202, 16'h040b, 16'h0402, 16'h0602, 16'h0002, 16'h0204,
                             16'h040c};

  fmc_top u_fmc_top (.mclk(mclk), .rst_n(rst_n), .mode_define_strobe(mode_define_strobe),
    .auxiliary_input_bus(auxiliary_input_bus), .real_in(real_in), .input_strobe(input_strobe),
    .load_start_input(load_start_input), .xform_done(xform_done), .dump_done(dump_done),
    .smp_ready(smp_ready), .smp_valid(smp_valid), .smp_data(smp_data),
    .load_progress_flag(load_progress_flag), .xform_go(xform_go), .loading(loading),
    .first_shift(first_shift), .plan(plan));
  fmc_sink_model u_fmc_sink_model (.mclk(mclk), .rst_n(rst_n), .clr(clr), .stall(stall),
    .ro(ro), .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready),
    .xform_go(xform_go), .xform_done(xform_done), .dump_done(dump_done), .got(got), .bad(bad));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic fmc_plan_t exp_plan(input logic [15:0] w);
    fmc_plan_t p;
    logic      big;
    big          = (w[2:0] == 3'h3) || (w[2:0] == 3'h6);
    p.pass_shift = w[3] ? 2'h2 : 2'h3;
    p.max_left   = w[3] ? 4'he : 4'hf;
    p.ovf_tag_en = w[3];
    p.concurrent = !big && !w[10];
    p.real_only  = w[2] && (w[10:9] == 2'h1 || w[10:9] == 2'h2);
    return p;
  endfunction

  // word on aux bus from define on, left there after the strobe drops
  task automatic define_word(input logic [15:0] w);
    fmc_plan_t p;
    p = exp_plan(w);
    @(negedge mclk);
    mode_define_strobe  = 1'b1;
    auxiliary_input_bus = w;
    @(negedge mclk);
    mode_define_strobe  = 1'b0;
    ro                  = p.real_only;
  endtask

  // start edge, stream samples, count flag falls until the load ends
  task automatic run_load(input logic [15:0] w, input int drop, input int falls,
                          input int tot, input logic st);
    int   n;
    int   f;
    int   d;
    int   k;
    logic fl;
    define_word(w);
    clr   = 1'b1;
    stall = st;
    @(negedge mclk);
    clr              = 1'b0;
    load_start_input = 1'b1;
    input_strobe     = 1'b1;
    n  = 0;
    f  = 0;
    d  = 0;
    fl = load_progress_flag;
    for (k = 0; k < 2000 && (n == 0 || loading); k++)
    begin
      @(negedge mclk);
      if (k == 3)
        load_start_input = 1'b0;
      if (k == 8)
        load_start_input = 1'b1;
      if (k == 100)
        stall = 1'b0;
      if (fl && !load_progress_flag)
      begin
        f++;
        if (d == 0)
          d = n;
      end
      fl = load_progress_flag;
      if (loading)
      begin
        n++;
        real_in             = n[15:0];
        auxiliary_input_bus = n[15:0] + 16'h0001;
      end
    end
    input_strobe = 1'b0;
    repeat (40) @(negedge mclk);
    if (!st)
    begin
      check(32'(d == drop || d == drop + 1), 32'h0000_0001, "flag drop point");
      check(32'(n), 32'(tot), "samples loaded");
    end
    check(32'(f), 32'(falls), "flag falls");
    check(32'(got), 32'(tot), "samples out");
    check(32'(bad), 32'h0000_0000, "sample order");
    check(32'(loading), 32'h0000_0000, "no restart without edge");
    check(32'(smp_valid), 32'h0000_0000, "buffer drained");
    load_start_input = 1'b0;
    $display("test load %h done", w);
    if (k >= 2000)
    begin
      err_count++;
      give_verdict();
    end
  endtask

  initial
  begin
    rst_n               = 1'b0;
    mode_define_strobe  = 1'b0;
    auxiliary_input_bus = 16'h0000;
    real_in             = 16'h0000;
    input_strobe        = 1'b0;
    load_start_input    = 1'b0;
    stall               = 1'b0;
    clr                 = 1'b0;
    ro                  = 1'b0;
    err_count           = 0;
    total_checks        = 0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    check(32'(load_progress_flag), 32'h0000_0001, "flag idle");
    check(32'(first_shift), 32'h0000_0002, "first pass shift");
    foreach (words[i])
    begin
      define_word(words[i]);
      check(32'(plan), 32'(exp_plan(words[i])), "plan decode");
    end
    auxiliary_input_bus = 16'hffff;
    repeat (3) @(negedge mclk);
    check(32'(plan), 32'(exp_plan(words[6])), "word held");
    $display("test mode decode done");
    run_load(16'h0200, 16, 1, 16, 1'b0);
    run_load(16'h02c2, 64, 1, 256, 1'b0);
    run_load(16'h0241, 32, 2, 256, 1'b0);
    run_load(16'h0441, 32, 1, 256, 1'b0);
    // special mode only below 1024 points
    run_load(16'h0642, 256, 1, 384, 1'b0);
    run_load(16'h0002, 256, 1, 256, 1'b1);
    run_load(16'h0205, 256, 2, 512, 1'b0);
    run_load(16'h0003, 1024, 1, 1024, 1'b0);
    give_verdict();
  end
endmodule
